// ==== src/svmf_defs.svh ====
// Purpose: offsets, field positions, reset values and timing counts of the
//          supply monitor register block
// Assumes: 200 MHz core clock, 32-bit APB data, one register per aligned word
// Notes:   definitions only
`ifndef SVMF_DEFS_SVH
`define SVMF_DEFS_SVH

// register byte offsets
`define SVMF_OFS_CTRL      8'h0C
`define SVMF_OFS_STAT      8'h10
`define SVMF_OFS_CLR       8'h14
`define SVMF_OFS_MASK      8'h18

// supply_monitor_control fields
`define SVMF_BIT_EN        0
`define SVMF_BIT_LOW       1
`define SVMF_BIT_HIGH      2
`define SVMF_CTRL_RST      8'h00

// interrupt status, clear and mask share one layout
`define SVMF_BIT_LOW_IRQ   5
`define SVMF_IRQ_RST       8'h00

// settling interval before the flags are valid
`define SVMF_CLK_NS        5
`define SVMF_SETTLE_NS     20000
`define SVMF_SETTLE_CYC    ((`SVMF_SETTLE_NS + `SVMF_CLK_NS - 1) / `SVMF_CLK_NS)

`endif

// ==== src/svmf_pkg.sv ====
// Purpose: types shared by the supply monitor block
// Assumes: nothing beyond the defs header
// Notes:   numbers live in svmf_defs.svh
package svmf_pkg;
  typedef logic [7:0] svmf_byte_t;

  // apb answer phase
  typedef enum logic [0:0]
  {
    SVMF_IDLE = 1'b0,
    SVMF_ANS  = 1'b1
  } svmf_apb_st_t;
endpackage

// ==== src/svmf_settle.sv ====
// Purpose: settling timer, reports when the monitor flags may be trusted
// Assumes: run stays high for the whole interval, otherwise the count restarts
// Notes:   settled is a registered level
`include "svmf_defs.svh"
module svmf_settle
  import svmf_pkg::*;
#(
  parameter int unsigned CYCLES = `SVMF_SETTLE_CYC,
  parameter int unsigned CW     = $clog2(CYCLES + 1)
)
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  // control
  input  wire logic run,
  output logic      settled
);
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic          settled_reg;
  logic          settled_next;

  // count up while running, stop at the end, restart whenever run drops
  always_comb
  begin
    cnt_next = cnt_reg;
    if (!run)
      cnt_next = '0;
    else if (cnt_reg != CW'(CYCLES))
      cnt_next = cnt_reg + CW'(1);
    settled_next = run && (cnt_next == CW'(CYCLES));
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_reg     <= '0;
      settled_reg <= 1'b0;
    end
    else if (ce)
    begin
      cnt_reg     <= cnt_next;
      settled_reg <= settled_next;
    end
  end

  assign settled = settled_reg;
endmodule

// ==== src/svmf_top.sv ====
// Purpose: supply monitor control, flags and low-supply interrupt over APB
// Assumes: comparator and stop inputs are synchronous to clk
// Notes:   pready answers one cycle after the access phase starts
//
// Chosen here: the APB interface to the registers.
`include "svmf_defs.svh"

module svmf_top
  import svmf_pkg::*;
#(
  parameter int unsigned AW            = 8,
  parameter int unsigned SETTLE_CYCLES = `SVMF_SETTLE_CYC
)
(
  // clock, reset, clock enable
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          ce,
  // apb slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [AW-1:0] paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  // analogue comparators and power state
  input  wire logic          cmp_below_low,
  input  wire logic          cmp_above_high,
  input  wire logic          stop_mode,
  // status out
  output logic               low_supply_flag,
  output logic               high_supply_flag,
  output logic               irq
);
  svmf_apb_st_t st_reg;
  svmf_apb_st_t st_next;
  logic [31:0]  prdata_reg;
  logic [31:0]  prdata_next;
  logic         pslverr_reg;
  logic         pslverr_next;
  logic         en_reg;
  logic         en_next;
  logic         low_reg;
  logic         low_next;
  logic         high_reg;
  logic         high_next;
  svmf_byte_t   stat_reg;
  svmf_byte_t   stat_next;
  svmf_byte_t   mask_reg;
  svmf_byte_t   mask_next;
  logic         irq_reg;
  logic         irq_next;
  logic         run;
  logic         settled;
  logic         wr_done;
  svmf_byte_t   clr_bits;
  svmf_byte_t   set_bits;

  // address decode, used for read data and for the error answer
  function automatic logic is_reg(input logic [AW-1:0] a, input logic [7:0] ofs);
    is_reg = (a == AW'(ofs));
  endfunction

  function automatic logic is_mapped(input logic [AW-1:0] a);
    is_mapped = is_reg(a, `SVMF_OFS_CTRL) || is_reg(a, `SVMF_OFS_STAT) ||
                is_reg(a, `SVMF_OFS_CLR) || is_reg(a, `SVMF_OFS_MASK);
  endfunction

  // monitor runs only while enabled and out of stop mode
  assign run = en_reg && !stop_mode;

  svmf_settle #(
    .CYCLES (SETTLE_CYCLES)
  ) u_settle (
    .clk     (clk),
    .rst     (rst),
    .ce      (ce),
    .run     (run),
    .settled (settled)
  );

  // a write lands only at the edge where pready is seen high
  assign wr_done = psel && penable && (st_reg == SVMF_ANS) && pwrite;

  // apb answer: one wait state, then a one-cycle pready pulse
  always_comb
  begin
    st_next      = SVMF_IDLE;
    prdata_next  = prdata_reg;
    pslverr_next = 1'b0;
    if (psel && penable && (st_reg == SVMF_IDLE))
    begin
      st_next      = SVMF_ANS;
      pslverr_next = !is_mapped(paddr);
      prdata_next  = 32'h0000_0000;
      if (!pwrite)
      begin
        if (is_reg(paddr, `SVMF_OFS_CTRL))
        begin
          // upper bits stay zero: reserved field
          prdata_next[`SVMF_BIT_EN]   = en_reg;
          prdata_next[`SVMF_BIT_LOW]  = low_reg;
          prdata_next[`SVMF_BIT_HIGH] = high_reg;
        end
        else if (is_reg(paddr, `SVMF_OFS_STAT))
          prdata_next[7:0] = stat_reg;
        else if (is_reg(paddr, `SVMF_OFS_MASK))
          prdata_next[7:0] = mask_reg;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_reg      <= SVMF_IDLE;
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end
    else if (ce)
    begin
      st_reg      <= st_next;
      prdata_reg  <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // control bit and comparator flags
  always_comb
  begin
    en_next = en_reg;
    if (wr_done && is_reg(paddr, `SVMF_OFS_CTRL))
      en_next = pwdata[`SVMF_BIT_EN];
    // flags held at zero until the comparators have settled
    low_next  = run && settled && cmp_below_low;
    high_next = run && settled && cmp_above_high;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      en_reg   <= 1'b0;
      low_reg  <= 1'b0;
      high_reg <= 1'b0;
    end
    else if (ce)
    begin
      en_reg   <= en_next;
      low_reg  <= low_next;
      high_reg <= high_next;
    end
  end

  // sticky request: a set in the clear cycle wins, so no event is lost
  always_comb
  begin
    clr_bits = 8'h00;
    set_bits = 8'h00;
    mask_next = mask_reg;
    if (wr_done && is_reg(paddr, `SVMF_OFS_CLR))
      clr_bits = pwdata[7:0];
    if (wr_done && is_reg(paddr, `SVMF_OFS_MASK))
      mask_next = pwdata[7:0];
    set_bits[`SVMF_BIT_LOW_IRQ] = low_reg && en_reg;
    stat_next = (stat_reg & ~clr_bits) | set_bits;
    irq_next  = |(stat_reg & mask_reg);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      stat_reg <= `SVMF_IRQ_RST;
      mask_reg <= `SVMF_IRQ_RST;
      irq_reg  <= 1'b0;
    end
    else if (ce)
    begin
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      irq_reg  <= irq_next;
    end
  end

  // outputs straight from flops
  assign prdata           = prdata_reg;
  assign pready           = (st_reg == SVMF_ANS);
  assign pslverr          = pslverr_reg;
  assign low_supply_flag  = low_reg;
  assign high_supply_flag = high_reg;
  assign irq              = irq_reg;

  // checks on the logic above
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // reset and enable
  en_reset_a: assert property ($past(rst) |-> !en_reg && !low_reg && !high_reg)
    else $error("enable or flags not zero after reset");

  en_write_a: assert property (
    ce && wr_done && is_reg(paddr, `SVMF_OFS_CTRL) |=> en_reg == $past(pwdata[0]))
    else $error("enable bit did not take the written value");

  // flag timing against the settling window
  settle_gate_a: assert property (ce && !settled |=> !low_reg && !high_reg)
    else $error("flag raised before settling");

  high_flag_a: assert property (
    ce && run && settled |=> high_reg == $past(cmp_above_high))
    else $error("high flag does not follow comparator");

  low_flag_a: assert property (
    ce && run && settled |=> low_reg == $past(cmp_below_low))
    else $error("low flag does not follow comparator");

  // request bit and interrupt output
  irq_set_a: assert property (ce && low_reg && en_reg |=> stat_reg[5])
    else $error("low flag did not set request bit");

  irq_hold_a: assert property (
    ce && stat_reg[5] && !(wr_done && is_reg(paddr, `SVMF_OFS_CLR) && pwdata[5])
    |=> stat_reg[5])
    else $error("request bit lost without a clear");

  irq_mask_a: assert property (
    ce |=> irq_reg == |($past(stat_reg) & $past(mask_reg)))
    else $error("interrupt output does not match masked status");

  // stop mode and reserved bits
  stop_off_a: assert property (ce && stop_mode |=> !low_reg && !high_reg)
    else $error("flags active in stop mode");

  reserved_a: assert property (
    pready && psel && !pwrite && is_reg(paddr, `SVMF_OFS_CTRL) |-> prdata[31:3] == '0)
    else $error("reserved control bits read nonzero");

  // read path, clear and mask; past ce keeps a stretched answer out
  ctrl_read_a: assert property (
    pready && psel && !pwrite && $past(ce) && is_reg(paddr, `SVMF_OFS_CTRL)
    |-> prdata[`SVMF_BIT_LOW] == $past(low_reg) && prdata[`SVMF_BIT_HIGH] == $past(high_reg))
    else $error("control read does not show the flags");

  clear_req_a: assert property (
    ce && wr_done && is_reg(paddr, `SVMF_OFS_CLR) && pwdata[`SVMF_BIT_LOW_IRQ] &&
    !(low_reg && en_reg) |=> !stat_reg[`SVMF_BIT_LOW_IRQ])
    else $error("clear write did not drop the request");

  mask_write_a: assert property (
    ce && wr_done && is_reg(paddr, `SVMF_OFS_MASK) |=> mask_reg == $past(pwdata[7:0]))
    else $error("mask did not take the written value");

  irq_masked_a: assert property (ce && !mask_reg[5] |=> !irq_reg)
    else $error("masked request reached the interrupt output");

  no_set_a: assert property (
    ce && !stat_reg[5] && !(low_reg && en_reg) |=> !stat_reg[5])
    else $error("request bit set without an enabled low flag");

  // comparator followers and the clock enable
  high_off_a: assert property (ce && !cmp_above_high |=> !high_reg)
    else $error("high flag set while the comparator is low");

  low_off_a: assert property (ce && !cmp_below_low |=> !low_reg)
    else $error("low flag set while the comparator is low");

  en_hold_a: assert property (
    ce && !(wr_done && is_reg(paddr, `SVMF_OFS_CTRL)) |=> $stable(en_reg))
    else $error("enable bit moved without a control write");

  ce_freeze_a: assert property (
    !ce && !rst |=> $stable(en_reg) && $stable(low_reg) && $stable(stat_reg))
    else $error("state moved while the clock enable was low");

  // scenarios worth seeing in a run
  settle_done_c: cover property (!settled ##1 settled);

  irq_rise_c: cover property (!irq_reg ##1 irq_reg);

  irq_clear_c: cover property (stat_reg[5] ##1 !stat_reg[5]);

  stop_cut_c: cover property (settled ##1 !settled);

  masked_req_c: cover property (stat_reg[5] && !mask_reg[5]);
endmodule

// ==== testbench/svmf_top_tb.sv ====
// Purpose: register-level test of the supply monitor block over APB
// Assumes: settling count cut to 8 cycles so the run stays short
// Notes:   comparators and stop state are driven straight by the bench
`include "svmf_defs.svh"
module svmf_top_tb
  import svmf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int unsigned SETTLE = 8;
  localparam int unsigned LIMIT  = 3000;

  logic        clk            = 1'b0;
  logic        rst            = 1'b1;
  logic        ce             = 1'b1;
  logic        psel           = 1'b0;
  logic        penable        = 1'b0;
  logic        pwrite         = 1'b0;
  logic [7:0]  paddr          = 8'h00;
  logic [31:0] pwdata         = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        cmp_below_low  = 1'b0;
  logic        cmp_above_high = 1'b0;
  logic        stop_mode      = 1'b0;
  logic        low_supply_flag;
  logic        high_supply_flag;
  logic        irq;
  logic [31:0] rd;
  logic        err;
  int          failures       = 0;
  int          check_count    = 0;
  int          cycles         = 0;

  svmf_top #(.AW(8), .SETTLE_CYCLES(SETTLE)) dut
  (
    .clk(clk), .rst(rst), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmp_below_low(cmp_below_low), .cmp_above_high(cmp_above_high),
    .stop_mode(stop_mode), .low_supply_flag(low_supply_flag),
    .high_supply_flag(high_supply_flag), .irq(irq)
  );

  // free-running 200 MHz clock
  always #2.5 clk = ~clk;

  // hang guard, the whole run needs under two hundred cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      failures++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // wait n edges, then sample away from the edge
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    // reset value, reserved bits, settling window
    apb(1'b0, `SVMF_OFS_CTRL, 32'h0, rd, err);
    chk(rd, 32'h00000000);
    apb(1'b1, `SVMF_OFS_CTRL, 32'h000000FF, rd, err);
    // comparators move only where a test moves them, no port switching noise
    cmp_below_low <= 1'b1;
    wt(2);
    chk(low_supply_flag, 32'h0);
    wt(SETTLE + 4);
    chk(low_supply_flag, 32'h1);
    apb(1'b0, `SVMF_OFS_CTRL, 32'h0, rd, err);
    chk(rd, 32'h00000003);
    cmp_above_high <= 1'b1;
    wt(2);
    chk(high_supply_flag, 32'h1);
    apb(1'b0, `SVMF_OFS_CTRL, 32'h0, rd, err);
    chk(rd, 32'h00000007);
    cmp_above_high <= 1'b0;
    $display("test flags done");
    // sticky request, mask and clear
    apb(1'b0, `SVMF_OFS_STAT, 32'h0, rd, err);
    chk(rd, 32'h00000020);
    chk(irq, 32'h0);
    apb(1'b1, `SVMF_OFS_MASK, 32'h00000020, rd, err);
    cmp_below_low <= 1'b0;
    wt(3);
    chk(irq, 32'h1);
    apb(1'b0, `SVMF_OFS_STAT, 32'h0, rd, err);
    chk(rd, 32'h00000020);
    apb(1'b1, `SVMF_OFS_CLR, 32'h00000020, rd, err);
    apb(1'b0, `SVMF_OFS_STAT, 32'h0, rd, err);
    chk(rd, 32'h00000000);
    apb(1'b0, `SVMF_OFS_CLR, 32'h0, rd, err);
    chk(rd, 32'h00000000);
    wt(2);
    chk(irq, 32'h0);
    $display("test request done");
    // stop mode halts monitoring, then it settles again
    @(posedge clk);
    cmp_below_low <= 1'b1;
    stop_mode     <= 1'b1;
    wt(SETTLE + 4);
    chk(low_supply_flag, 32'h0);
    apb(1'b0, `SVMF_OFS_STAT, 32'h0, rd, err);
    chk(rd, 32'h00000000);
    stop_mode <= 1'b0;
    wt(SETTLE + 4);
    chk(low_supply_flag, 32'h1);
    // clock enable low freezes the flags, then they follow again
    @(posedge clk);
    ce            <= 1'b0;
    cmp_below_low <= 1'b0;
    wt(3);
    chk(low_supply_flag, 32'h1);
    @(posedge clk);
    ce <= 1'b1;
    wt(2);
    chk(low_supply_flag, 32'h0);
    @(posedge clk);
    cmp_below_low <= 1'b1;
    wt(2);
    chk(low_supply_flag, 32'h1);
    apb(1'b1, `SVMF_OFS_CTRL, 32'h0, rd, err);
    wt(2);
    chk(low_supply_flag, 32'h0);
    $display("test stop done");
    // unmapped address answers with an error and zero data
    apb(1'b0, 8'h40, 32'h0, rd, err);
    chk(err, 32'h1);
    chk(rd, 32'h00000000);
    $display("test unmapped done");
    // mask already armed before monitoring starts with the supply low
    apb(1'b1, `SVMF_OFS_CLR, 32'h00000020, rd, err);
    wt(2);
    chk(irq, 32'h0);
    apb(1'b1, `SVMF_OFS_CTRL, 32'h00000001, rd, err);
    wt(SETTLE + 4);
    chk(irq, 32'h1);
    apb(1'b0, `SVMF_OFS_STAT, 32'h0, rd, err);
    chk(rd, 32'h00000020);
    $display("test early arm done");
    print_verdict();
  end
endmodule
